/* logic/uce_params.svh */
`ifndef UCE_PARAMS_SVH
`define UCE_PARAMS_SVH

// ------------------------------------------------------------
// register offsets (vendor request index)
// ------------------------------------------------------------
`define UCE_ADDR_ENABLE   10'h000
`define UCE_ADDR_FLOW     10'h006
`define UCE_ADDR_RESUME   10'h007
`define UCE_ADDR_PAUSE    10'h008
`define UCE_ADDR_ERRSTAT  10'h009
`define UCE_ADDR_PERBYTE  10'h045
`define UCE_ADDR_USBSTAT  10'h262

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UCE_EN_TX_BIT     0
`define UCE_EN_RX_BIT     1
`define UCE_FC_HDX_BIT    3
`define UCE_FC_MODE_MSB   2
`define UCE_ES_BRK_BIT    3
`define UCE_ES_FRM_BIT    4
`define UCE_ES_PAR_BIT    5
`define UCE_ES_OVR_BIT    6
`define UCE_ES_LIVE_BIT   7
`define UCE_PB_EN_BIT     0

// ------------------------------------------------------------
// reset values, usb status read mask
// ------------------------------------------------------------
`define UCE_RST_ENABLE    2'h0
`define UCE_RST_FLOW      4'h0
`define UCE_RST_RESUME    8'h11
`define UCE_RST_PAUSE     8'h13
`define UCE_RST_ERR       4'h0
`define UCE_USB_MASK      16'h3f3f

`endif

/* logic/uce_pkg.sv */
package uce_pkg;

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    UCE_MODE_NONE  = 3'b000,
    UCE_MODE_HW    = 3'b001,
    UCE_MODE_SW    = 3'b010,
    UCE_MODE_MDRX  = 3'b011,
    UCE_MODE_MDALL = 3'b100
  } uce_mode_t;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } uce_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [8:0] data;
    logic       parityErr;
    logic       frameErr;
    logic       breakEvt;
  } uce_rx_evt_t;

  // err: {overrun, parity, framing, break}
  typedef struct packed {
    logic       valid;
    logic       ninth;
    logic [7:0] data;
    logic [3:0] err;
  } uce_rx_out_t;

  typedef struct packed {
    logic [1:0]  enable;
    logic        halfDuplex;
    logic [2:0]  mode;
    logic [7:0]  resumeChar;
    logic [7:0]  pauseChar;
    logic        perByte;
    logic        txPaused;
    logic        addrMatched;
    logic        ctsMeta;
    logic        ctsSync;
    logic        rtsN;
    logic [15:0] rdData;
    logic        rdValid;
    uce_rx_out_t rxOut;
  } uce_state_t;

endpackage

/* logic/uce_sticky_flags.sv */
`timescale 1ns/100ps

module uce_sticky_flags #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // events and clear
  input  wire logic [W-1:0] setVec,
  input  wire logic         clrStrobe,
  // held flags
  output logic      [W-1:0] flags
);
  import uce_pkg::*;

  typedef struct packed {
    logic [W-1:0] flags;
  } uce_sticky_st_t;

  uce_sticky_st_t st_q;
  uce_sticky_st_t st_d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // an event in the clearing cycle survives the clear
  always_comb
  begin
    st_d = st_q;
    st_d.flags = setVec | (st_q.flags & ~{W{clrStrobe}});
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

endmodule

/* logic/uce_serial_ctrl.sv */
`timescale 1ns/100ps


`include "uce_params.svh"

module uce_serial_ctrl (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // vendor register requests
  input  wire uce_pkg::uce_reg_req_t regReq,
  output logic               [15:0] regRdData,
  output logic                      regRdValid,
  // usb link state, read only
  input  wire logic          [15:0] usbLinkState,
  // receiver events
  input  wire uce_pkg::uce_rx_evt_t rxEvt,
  input  wire logic                 rxBreakLive,
  input  wire logic                 rxFifoFull,
  // transmitter status
  input  wire logic                 txBusy,
  // handshake pins
  input  wire logic                 ctsPinN,
  output logic                      rtsPinN,
  // control out
  output logic                      rxEnable,
  output logic                      txEnable,
  output logic                      txAllowed,
  output uce_pkg::uce_rx_out_t      rxOut
);
  import uce_pkg::*;

  uce_state_t st_q;
  uce_state_t st_d;

  logic       wrEnable;
  logic       wrFlow;
  logic       wrResume;
  logic       wrPause;
  logic       wrPerByte;
  logic       rdErrStat;
  logic       rxTaking;
  logic       evtTaken;
  logic       isAddrChar;
  logic       hitPause;
  logic       hitResume;
  logic       hitAddr;
  logic       consumed;
  logic       gateOk;
  logic       deliver;
  logic       overrun;
  logic [3:0] errSet;
  logic [3:0] errFlags;
  logic [15:0] errWord;
  uce_mode_t  mode;

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  // no write lockout; host disables first
  assign wrEnable  = regReq.wr && (regReq.addr == `UCE_ADDR_ENABLE);
  assign wrFlow    = regReq.wr && (regReq.addr == `UCE_ADDR_FLOW);
  assign wrResume  = regReq.wr && (regReq.addr == `UCE_ADDR_RESUME);
  assign wrPause   = regReq.wr && (regReq.addr == `UCE_ADDR_PAUSE);
  assign wrPerByte = regReq.wr && (regReq.addr == `UCE_ADDR_PERBYTE);
  assign rdErrStat = regReq.rd && (regReq.addr == `UCE_ADDR_ERRSTAT);

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  // reserved codes fall back to plain mode
  always_comb
  begin
    unique case (st_q.mode)
      3'b000:  mode = UCE_MODE_NONE;
      3'b001:  mode = UCE_MODE_HW;
      3'b010:  mode = UCE_MODE_SW;
      3'b011:  mode = UCE_MODE_MDRX;
      3'b100:  mode = UCE_MODE_MDALL;
      default: mode = UCE_MODE_NONE;
    endcase
  end

  // ------------------------------------------------------------
  // receive path qualification
  // ------------------------------------------------------------
  // half-duplex ignores line while sending
  assign rxTaking = st_q.enable[`UCE_EN_RX_BIT]
                    && !(st_q.halfDuplex && txBusy);
  assign evtTaken = rxEvt.valid && rxTaking;

  // address characters carry the ninth bit
  assign isAddrChar = rxEvt.data[8];

  // flow characters compared with ninth bit zero
  assign hitPause  = (rxEvt.data == {1'b0, st_q.pauseChar});
  assign hitResume = (rxEvt.data == {1'b0, st_q.resumeChar});

  assign hitAddr = (rxEvt.data[7:0] == st_q.resumeChar)
                   || (rxEvt.data[7:0] == st_q.pauseChar);

  // flow and address characters are eaten, not stored
  always_comb
  begin
    consumed = 1'b0;
    gateOk   = 1'b1;
    unique case (mode)
      UCE_MODE_SW:
      begin
        consumed = hitPause || hitResume;
      end
      UCE_MODE_MDRX, UCE_MODE_MDALL:
      begin
        consumed = isAddrChar;
        gateOk   = st_q.addrMatched;
      end
      default:
      begin
        consumed = 1'b0;
        gateOk   = 1'b1;
      end
    endcase
  end

  assign deliver = evtTaken && !consumed && gateOk;

  // full fifo turns the byte into an overrun
  assign overrun = deliver && rxFifoFull;

  // ------------------------------------------------------------
  // error accumulation
  // ------------------------------------------------------------
  // events gathered since last read
  assign errSet = {overrun,
                   evtTaken && rxEvt.parityErr,
                   evtTaken && rxEvt.frameErr,
                   evtTaken && rxEvt.breakEvt};

  uce_sticky_flags #(
    .W (4)
  ) u_err (
    .clk      (clk),
    .rstn     (rstn),
    .setVec   (errSet),
    .clrStrobe (rdErrStat),
    .flags    (errFlags)
  );

  always_comb
  begin
    errWord = 16'h0000;
    errWord[`UCE_ES_LIVE_BIT] = rxBreakLive;
    errWord[`UCE_ES_OVR_BIT]  = errFlags[3];
    errWord[`UCE_ES_PAR_BIT]  = errFlags[2];
    errWord[`UCE_ES_FRM_BIT]  = errFlags[1];
    errWord[`UCE_ES_BRK_BIT]  = errFlags[0];
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    if (wrEnable)
    begin
      st_d.enable[`UCE_EN_RX_BIT] = regReq.wdata[`UCE_EN_RX_BIT];
      st_d.enable[`UCE_EN_TX_BIT] = regReq.wdata[`UCE_EN_TX_BIT];
    end

    if (wrFlow)
    begin
      st_d.halfDuplex = regReq.wdata[`UCE_FC_HDX_BIT];
      st_d.mode       = regReq.wdata[`UCE_FC_MODE_MSB:0];
    end

    if (wrResume)
    begin
      st_d.resumeChar = regReq.wdata[7:0];
    end

    if (wrPause)
    begin
      st_d.pauseChar = regReq.wdata[7:0];
    end

    if (wrPerByte)
    begin
      st_d.perByte = regReq.wdata[`UCE_PB_EN_BIT];
    end

    // software pause and resume
    if (evtTaken && (mode == UCE_MODE_SW))
    begin
      if (hitPause)
      begin
        st_d.txPaused = 1'b1;
      end
      else if (hitResume)
      begin
        st_d.txPaused = 1'b0;
      end
    end

    // address char sets or drops the match
    if (evtTaken && isAddrChar
        && ((mode == UCE_MODE_MDRX) || (mode == UCE_MODE_MDALL)))
    begin
      st_d.addrMatched = hitAddr;
    end

    // stale pause or match must not outlive disabling both rx and tx
    if (st_q.enable == 2'b00)
    begin
      st_d.txPaused    = 1'b0;
      st_d.addrMatched = 1'b0;
    end

    // two-flop pin synchroniser
    st_d.ctsMeta = ctsPinN;
    st_d.ctsSync = st_q.ctsMeta;

    // hardware handshake: ask remote to hold off when full
    st_d.rtsN = (mode == UCE_MODE_HW) && rxFifoFull;

    // errors travel with each byte when selected
    st_d.rxOut.valid = deliver && !rxFifoFull;
    if (deliver)
    begin
      st_d.rxOut.ninth = rxEvt.data[8];
      st_d.rxOut.data  = rxEvt.data[7:0];
      st_d.rxOut.err   = st_q.perByte ? errSet : 4'h0;
    end

    // register reads, answered one cycle later
    st_d.rdValid = regReq.rd;
    if (regReq.rd)
    begin
      st_d.rdData = 16'h0000;
      unique case (regReq.addr)
        `UCE_ADDR_ENABLE:
        begin
          st_d.rdData[1:0] = st_q.enable;
        end
        `UCE_ADDR_FLOW:
        begin
          st_d.rdData[`UCE_FC_HDX_BIT] = st_q.halfDuplex;
          st_d.rdData[`UCE_FC_MODE_MSB:0] = st_q.mode;
        end
        `UCE_ADDR_RESUME:
        begin
          st_d.rdData[7:0] = st_q.resumeChar;
        end
        `UCE_ADDR_PAUSE:
        begin
          st_d.rdData[7:0] = st_q.pauseChar;
        end
        `UCE_ADDR_ERRSTAT:
        begin
          st_d.rdData = errWord;
        end
        `UCE_ADDR_PERBYTE:
        begin
          st_d.rdData[`UCE_PB_EN_BIT] = st_q.perByte;
        end
        `UCE_ADDR_USBSTAT:
        begin
          st_d.rdData = usbLinkState & `UCE_USB_MASK;
        end
        default:
        begin
          st_d.rdData = 16'h0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q             <= '0;
      st_q.enable      <= `UCE_RST_ENABLE;
      st_q.resumeChar  <= `UCE_RST_RESUME;
      st_q.pauseChar   <= `UCE_RST_PAUSE;
      st_q.ctsMeta     <= 1'b1;
      st_q.ctsSync     <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign regRdData  = st_q.rdData;
  assign regRdValid = st_q.rdValid;
  assign rtsPinN    = st_q.rtsN;
  assign rxEnable   = st_q.enable[`UCE_EN_RX_BIT];
  assign txEnable   = st_q.enable[`UCE_EN_TX_BIT];
  assign rxOut      = st_q.rxOut;

  // transmit permission per mode
  always_comb
  begin
    unique case (mode)
      UCE_MODE_HW:
      begin
        txAllowed = txEnable && !st_q.ctsSync;
      end
      UCE_MODE_SW:
      begin
        txAllowed = txEnable && !st_q.txPaused;
      end
      UCE_MODE_MDALL:
      begin
        txAllowed = txEnable && st_q.addrMatched;
      end
      default:
      begin
        txAllowed = txEnable;
      end
    endcase
  end

endmodule

/* verification/uce_serial_ctrl_sva.sv */
`timescale 1ns/100ps

module uce_serial_ctrl_sva (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // register port
  input wire uce_pkg::uce_reg_req_t regReq,
  input wire logic           [15:0] regRdData,
  input wire logic                  regRdValid,
  // receive side and control
  input wire uce_pkg::uce_rx_evt_t  rxEvt,
  input wire logic                  rxBreakLive,
  input wire logic                  rxFifoFull,
  input wire logic                  rxEnable,
  input wire logic                  txEnable,
  input wire logic                  txAllowed,
  input wire uce_pkg::uce_rx_out_t  rxOut
);
  import uce_pkg::*;
  logic [1:0] enWr;
  logic       enHit;
  logic       errRd;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  assign enWr  = regReq.wdata[1:0];
  assign enHit = regReq.wr && regReq.addr == 10'h000;
  assign errRd = regReq.rd && regReq.addr == 10'h009;

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_rdAnswer;
    regReq.rd |=> regRdValid;
  endproperty
  property p_noSpurious;
    !regReq.rd |=> !regRdValid;
  endproperty
  property p_rdHold;
    !regReq.rd |=> $stable(regRdData);
  endproperty
  property p_enable;
    enHit |=> {rxEnable, txEnable} == $past(enWr);
  endproperty
  property p_enHold;
    !enHit |=> $stable(rxEnable) && $stable(txEnable);
  endproperty
  property p_liveBreak;
    errRd |=> regRdData[7] == $past(rxBreakLive);
  endproperty
  property p_errRsv;
    errRd |=> regRdData[15:8] == 8'h00 && regRdData[2:0] == 3'h0;
  endproperty
  property p_overrun;
    rxEvt.valid && rxFifoFull |=> !rxOut.valid;
  endproperty
  property p_rxCause;
    rxOut.valid |-> $past(rxEvt.valid) && $past(rxEnable);
  endproperty
  property p_txGate;
    txAllowed |-> txEnable;
  endproperty

  a_rdAnswer:   assert property (p_rdAnswer)   else $error("no read answer");
  a_noSpurious: assert property (p_noSpurious) else $error("stray answer");
  a_rdHold:     assert property (p_rdHold)     else $error("data moved");
  a_enable:     assert property (p_enable)     else $error("enable bits");
  a_enHold:     assert property (p_enHold)     else $error("enable moved");
  a_liveBreak:  assert property (p_liveBreak)  else $error("live break");
  a_errRsv:     assert property (p_errRsv)     else $error("status rsv");
  a_overrun:    assert property (p_overrun)    else $error("full fifo");
  a_rxCause:    assert property (p_rxCause)    else $error("stray rx");
  a_txGate:     assert property (p_txGate)     else $error("tx gate");

  c_errSeen: cover property (errRd ##1 regRdData[6:3] != 4'h0);
  c_rxOut:   cover property (rxOut.valid);
  c_paused:  cover property (txEnable && $fell(txAllowed));
endmodule

bind uce_serial_ctrl uce_serial_ctrl_sva chk (
  .clk(clk), .rstn(rstn), .regReq(regReq), .regRdData(regRdData),
  .regRdValid(regRdValid), .rxEvt(rxEvt), .rxBreakLive(rxBreakLive),
  .rxFifoFull(rxFifoFull), .rxEnable(rxEnable), .txEnable(txEnable),
  .txAllowed(txAllowed), .rxOut(rxOut));

/* verification/uce_remote_dev.sv */
`timescale 1ns/100ps

module uce_remote_dev (
  // clock
  input  wire logic            clk,
  // lines toward the block
  output uce_pkg::uce_rx_evt_t rxEvt,
  output logic                 ctsPinN
);
  import uce_pkg::*;
  initial
  begin
    rxEvt   = '0;
    ctsPinN = 1'b0;
  end
  task automatic sendChar(input logic [8:0] d, input logic [2:0] e);
    @(negedge clk);
    rxEvt = {1'b1, d, e};
    @(negedge clk);
    // released: inverted data, never the stale value
    rxEvt = {1'b0, ~d, 3'h0};
  endtask
  task automatic holdOff(input logic v);
    @(negedge clk);
    ctsPinN = v;
  endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/100ps
`include "uce_params.svh"
`define CHK(nm, exp, got) \
  begin \
    numChecks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("MISMATCH %s exp %h got %h", nm, exp, got); \
    end \
  end

module tb_top;
  import uce_pkg::*;
  logic         clk = 1'b0;
  logic         rstn, regRdValid, rxBreakLive, rxFifoFull, txBusy;
  logic         ctsPinN, rtsPinN, rxEnable, txEnable, txAllowed;
  logic  [15:0] regRdData, usbLinkState;
  uce_reg_req_t regReq;
  uce_rx_evt_t  rxEvt;
  uce_rx_out_t  rxOut;
  int           fails = 0;
  int           numChecks = 0;
  int           cycles = 0;

  uce_serial_ctrl dut (.clk(clk), .rstn(rstn), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .usbLinkState(usbLinkState), .rxEvt(rxEvt), .rxBreakLive(rxBreakLive),
    .rxFifoFull(rxFifoFull), .txBusy(txBusy), .ctsPinN(ctsPinN),
    .rtsPinN(rtsPinN), .rxEnable(rxEnable), .txEnable(txEnable),
    .txAllowed(txAllowed), .rxOut(rxOut));
  uce_remote_dev remote (.clk(clk), .rxEvt(rxEvt), .ctsPinN(ctsPinN));

  always #20 clk = ~clk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // whole suite needs about 160 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      tallyAndFinish();
    end
  end
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    regReq.wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e,
                    input string nm);
    @(negedge clk);
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    regReq.rd = 1'b0;
    `CHK({nm, " valid"}, 1'b1, regRdValid)
    `CHK(nm, e, regRdData)
  endtask
  task automatic rx(input logic [8:0] d, input logic [2:0] e,
                    input logic v, input logic [7:0] xd, input string nm);
    remote.sendChar(d, e);
    #1;
    `CHK({nm, " valid"}, v, rxOut.valid)
    if (v)
      `CHK({nm, " data"}, xd, rxOut.data)
  endtask
  task automatic mode(input logic [15:0] f);
    wr(`UCE_ADDR_ENABLE, 16'h0000);
    wr(`UCE_ADDR_FLOW, f);
    wr(`UCE_ADDR_ENABLE, 16'h0003);
    #1;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    regReq = '0;
    usbLinkState = 16'hffff;
    rxBreakLive = 1'b0;
    rxFifoFull = 1'b0;
    txBusy = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rd(`UCE_ADDR_ENABLE, 16'h0000, "enable rst");
    rd(`UCE_ADDR_FLOW, 16'h0000, "flow rst");
    rd(`UCE_ADDR_RESUME, 16'h0011, "resume rst");
    rd(`UCE_ADDR_PAUSE, 16'h0013, "pause rst");
    wr(`UCE_ADDR_ERRSTAT, 16'h00ff);
    rd(`UCE_ADDR_ERRSTAT, 16'h0000, "err rst");
    rd(10'h100, 16'h0000, "unmapped");
    rd(`UCE_ADDR_USBSTAT, 16'h3f3f, "usb state");
    wr(`UCE_ADDR_ENABLE, 16'h0003);
    rd(`UCE_ADDR_ENABLE, 16'h0003, "enable");
    wr(`UCE_ADDR_ENABLE, 16'h0000);
    wr(`UCE_ADDR_RESUME, 16'h00a5);
    wr(`UCE_ADDR_PAUSE, 16'h005a);
    rd(`UCE_ADDR_RESUME, 16'h00a5, "resume");
    rd(`UCE_ADDR_PAUSE, 16'h005a, "pause");
    $display("test registers done");
    mode(16'h0002);
    `CHK("tx open", 1'b1, txAllowed)
    rx(9'h05a, 3'h0, 1'b0, 8'h00, "pause char");
    `CHK("tx paused", 1'b0, txAllowed)
    rx(9'h041, 3'h0, 1'b1, 8'h41, "data paused");
    rx(9'h0a5, 3'h0, 1'b0, 8'h00, "resume char");
    `CHK("tx resumed", 1'b1, txAllowed)
    $display("test software flow done");
    mode(16'h0000);
    rx(9'h031, 3'h4, 1'b1, 8'h31, "parity char");
    rx(9'h032, 3'h2, 1'b1, 8'h32, "frame char");
    rxFifoFull = 1'b1;
    rx(9'h000, 3'h1, 1'b0, 8'h00, "full break");
    rxFifoFull = 1'b0;
    rxBreakLive = 1'b1;
    rd(`UCE_ADDR_ERRSTAT, 16'h00f8, "err all");
    rd(`UCE_ADDR_ERRSTAT, 16'h0080, "err cleared");
    rxBreakLive = 1'b0;
    $display("test error status done");
    wr(`UCE_ADDR_ENABLE, 16'h0000);
    wr(`UCE_ADDR_PERBYTE, 16'h0001);
    rd(`UCE_ADDR_PERBYTE, 16'h0001, "perbyte reg");
    mode(16'h0000);
    rx(9'h034, 3'h4, 1'b1, 8'h34, "perbyte");
    `CHK("perbyte err", 4'h4, rxOut.err)
    rd(`UCE_ADDR_ERRSTAT, 16'h0020, "perbyte status");
    wr(`UCE_ADDR_ENABLE, 16'h0000);
    wr(`UCE_ADDR_PERBYTE, 16'h0000);
    mode(16'h0008);
    rd(`UCE_ADDR_FLOW, 16'h0008, "flow hdx");
    txBusy = 1'b1;
    rx(9'h035, 3'h4, 1'b0, 8'h00, "hdx drop");
    txBusy = 1'b0;
    rx(9'h036, 3'h0, 1'b1, 8'h36, "hdx pass");
    rd(`UCE_ADDR_ERRSTAT, 16'h0000, "hdx err");
    // an error arriving with the clearing read must survive it
    fork
      rd(`UCE_ADDR_ERRSTAT, 16'h0000, "clear race");
      rx(9'h037, 3'h4, 1'b1, 8'h37, "race char");
    join
    rd(`UCE_ADDR_ERRSTAT, 16'h0020, "set wins");
    $display("test per-byte and half-duplex done");
    wr(`UCE_ADDR_ENABLE, 16'h0000);
    wr(`UCE_ADDR_RESUME, 16'h0022);
    wr(`UCE_ADDR_PAUSE, 16'h0033);
    mode(16'h0003);
    rx(9'h055, 3'h0, 1'b0, 8'h00, "no match");
    rx(9'h122, 3'h0, 1'b0, 8'h00, "unicast addr");
    rx(9'h055, 3'h0, 1'b1, 8'h55, "unicast data");
    rx(9'h144, 3'h0, 1'b0, 8'h00, "other addr");
    rx(9'h066, 3'h0, 1'b0, 8'h00, "unmatched");
    rx(9'h133, 3'h0, 1'b0, 8'h00, "multicast addr");
    rx(9'h077, 3'h0, 1'b1, 8'h77, "multicast data");
    mode(16'h0004);
    `CHK("tx unmatched", 1'b0, txAllowed)
    rx(9'h122, 3'h0, 1'b0, 8'h00, "tx addr");
    `CHK("tx matched", 1'b1, txAllowed)
    $display("test multidrop done");
    mode(16'h0001);
    rxFifoFull = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("rts hold", 1'b1, rtsPinN)
    rxFifoFull = 1'b0;
    remote.holdOff(1'b1);
    repeat (4) @(negedge clk);
    `CHK("rts free", 1'b0, rtsPinN)
    `CHK("cts stop", 1'b0, txAllowed)
    remote.holdOff(1'b0);
    repeat (4) @(negedge clk);
    `CHK("cts go", 1'b1, txAllowed)
    $display("test hardware flow done");
    tallyAndFinish();
  end
endmodule
